// ---- design/count_tick_gen.v ----
// count clock enable generator, one pulse every divide cycles
`timescale 1ns/1ps
module count_tick_gen #(
    parameter DIV = 4
) (
    // clock and reset
    input  wire       pclk,
    input  wire       presetn,
    input  wire       clk_en,
    // control
    input  wire       run,
    // tick out
    output wire       tick
);
    // ==========================================
    // divider
    reg  [15:0] div_r;
    wire [15:0] div_last = DIV[15:0] - 16'h0001;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 16'h0000;
        end else if (clk_en) begin
            if (!run || div_r == div_last) begin
                div_r <= 16'h0000;
            end else begin
                div_r <= div_r + 16'h0001;
            end
        end
    end

    // restarts with each run, so the first interval is always whole
    assign tick = run && clk_en && (div_r == div_last);
endmodule // count_tick_gen

// ---- design/interval_timer.v ----
// interval timer with mode table, output pin control and apb register file
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "interval_timer_map.vh"

// How it works
// - triggers are recorded only in trigger and one-shot modes and never gate counting
// - channels compare, except pulse-width and free-run with control one bit 4 set
// - batch reload in trigger and pwm modes
// - mode 000 with run gives interval timer
// - pin 0 square wave, half period interval
// - run start: FFFF to 0000, toggle pin0
// - run start copies compare 0 to buffer
// - match clears counter, toggles, raises interrupt
// - interval is compare plus one counts
// - enable bit drives timer output onto pin
// - level bit sets pin while disabled
module interval_timer #(
    parameter PRESCALE = `PRESCALE_DEF
) (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // pins
    input  wire        trig_pin,
    input  wire        event_pin,
    output wire [3:0]  timer_out,
    // interrupt and status
    output wire        irq,
    output wire        channel0_match_irq,
    output wire        capture_mode
);
    // ==========================================
    // registers
    reg  [7:0]  timer_control_zero_r;
    reg  [7:0]  timer_control_one_r;
    reg  [7:0]  timer_output_control_r;
    reg  [7:0]  input_edge_control_r;
    reg  [15:0] cmp_r [0:3];
    reg  [15:0] cmp_buf_r [0:3];
    reg  [15:0] count_r;
    reg  [3:0]  tout_r;
    reg  [3:0]  stat_r;
    reg  [3:0]  mask_r;
    reg         running_r;
    reg         reload_pend_r;
    reg         trig_seen_r;
    reg  [2:0]  trig_sync_r;
    reg  [2:0]  evt_sync_r;
    reg         match0_r;

    wire [2:0]  mode      = timer_control_one_r[`CTL1_MODE_MSB:`CTL1_MODE_LSB];
    wire        run       = timer_control_zero_r[`CTL0_RUN_BIT];
    wire        ext_clk   = timer_control_one_r[`CTL1_EXT_CLK];
    wire        wr_access = psel && penable && pwrite;
    wire        rd_access = psel && penable && !pwrite;
    wire        mapped;
    wire        tick_int;
    wire        evt_edge;
    wire        tick;
    wire        trig_edge;
    wire        trig_ok;
    wire        batch;
    wire        cnt_last;
    wire [3:0]  match;
    wire [3:0]  stat_set;
    wire [1:0]  cmp_idx   = paddr[3:2];
    // aligned words 0x10 to 0x1C only, an unaligned write is refused
    wire        cmp_wr    = wr_access && ((paddr & 12'hFF3) == `OFS_CMP0);

    // ==========================================
    // mode table
    assign trig_ok      = (mode == `MODE_EXT_TRIG) || (mode == `MODE_ONE_SHOT);
    assign capture_mode = (mode == `MODE_PULSE_W) ||
                          ((mode == `MODE_FREE_RUN) && timer_control_one_r[4]);
    assign batch        = (mode == `MODE_EXT_TRIG) || (mode == `MODE_PWM) ||
                          (mode == `MODE_TRI_PWM);

    // ==========================================
    // pin synchronisers, a rising edge counts when stage two is high and stage three is low
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_sync_r <= 3'h0;
            evt_sync_r  <= 3'h0;
        end else if (clk_en) begin
            trig_sync_r <= {trig_sync_r[1:0], trig_pin};
            evt_sync_r  <= {evt_sync_r[1:0], event_pin};
        end
    end
    assign trig_edge = trig_sync_r[1] && !trig_sync_r[2];
    assign evt_edge  = evt_sync_r[1] && !evt_sync_r[2] && clk_en;

    count_tick_gen #(
        .DIV (PRESCALE)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .run     (run),
        .tick    (tick_int)
    );

    // event counting in event mode or with the external clock bit set; software keeps the edge field clear
    assign tick = (ext_clk || mode == `MODE_EVENT) ? (run && evt_edge) : tick_int;

    // ==========================================
    // counter and compare
    assign cnt_last = (count_r == cmp_buf_r[0]);

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_ch
            assign match[g] = running_r && tick && !capture_mode &&
                              (count_r == cmp_buf_r[g]);
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cmp_r[g]     <= `RST_CMP;
                    cmp_buf_r[g] <= `RST_CMP;
                    tout_r[g]    <= 1'b0;
                end else if (clk_en) begin
                    if (cmp_wr && cmp_idx == g) begin
                        cmp_r[g] <= pwdata[15:0];
                    end
                    if (run && !running_r && tick) begin
                        cmp_buf_r[g] <= cmp_r[g];
                    end else if (!batch) begin
                        cmp_buf_r[g] <= cmp_r[g];
                    end else if (reload_pend_r && match[0]) begin
                        cmp_buf_r[g] <= cmp_r[g];
                    end
                    if (!run) begin
                        tout_r[g] <= 1'b0;
                    end else if ((g == 0 && run && !running_r && tick) || match[g]) begin
                        tout_r[g] <= ~tout_r[g];
                    end
                end
            end
            // disabled pin shows its idle level
            assign timer_out[g] = timer_output_control_r[2*g] ? tout_r[g] :
                                  timer_output_control_r[2*g+1];
        end
    endgenerate

    // trigger modes do not wait for a trigger; counting starts on the first tick after run
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r       <= `CNT_IDLE;
            running_r     <= 1'b0;
            reload_pend_r <= 1'b0;
            trig_seen_r   <= 1'b0;
            match0_r      <= 1'b0;
        end else if (clk_en) begin
            match0_r <= match[0];
            if (!run) begin
                count_r     <= `CNT_IDLE;
                running_r   <= 1'b0;
                trig_seen_r <= 1'b0;
            end else begin
                if (trig_ok && (trig_edge ||
                    (wr_access && paddr == `OFS_CTL1 && pwdata[`CTL1_SW_TRIG]))) begin
                    trig_seen_r <= 1'b1;
                end
                if (tick) begin
                    if (!running_r) begin
                        count_r   <= `CNT_ZERO;
                        running_r <= 1'b1;
                    end else if (cnt_last) begin
                        count_r <= `CNT_ZERO;
                    end else begin
                        count_r <= count_r + 16'h0001;
                    end
                end
            end
            if (cmp_wr && batch) begin
                reload_pend_r <= 1'b1;
            end else if (match[0]) begin
                reload_pend_r <= 1'b0;
            end
        end
    end

    assign channel0_match_irq = match0_r;

    // ==========================================
    // interrupt status, read of status clears, new event wins
    assign stat_set = match;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= 4'h0;
        end else if (clk_en) begin
            if (rd_access && paddr == `OFS_IRQ_STAT) begin
                stat_r <= stat_set;
            end else begin
                stat_r <= stat_r | stat_set;
            end
        end
    end
    assign irq = |(stat_r & mask_r);

    // ==========================================
    // apb slave, zero wait
    assign pready  = 1'b1;
    assign mapped  = (paddr <= `OFS_IRQ_MASK) && (paddr[1:0] == 2'b00);
    assign pslverr = psel && penable && !mapped;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_zero_r   <= `RST_CTL0;
            timer_control_one_r    <= `RST_CTL1;
            timer_output_control_r <= `RST_OUT_CTL;
            input_edge_control_r   <= `RST_IN_EDGE;
            mask_r                 <= `RST_MASK;
        end else if (clk_en && wr_access) begin
            case (paddr)
                `OFS_CTL0:     timer_control_zero_r   <= pwdata[7:0];
                // software trigger bit is a strobe, never stored
                `OFS_CTL1:     timer_control_one_r    <= {1'b0, pwdata[6:0] & 7'h3F};
                `OFS_OUT_CTL:  timer_output_control_r <= pwdata[7:0];
                `OFS_IN_EDGE:  input_edge_control_r   <= pwdata[7:0];
                `OFS_IRQ_MASK: mask_r                 <= pwdata[3:0];
                default:       mask_r                 <= mask_r;
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (clk_en && psel && !penable && !pwrite) begin
            case (paddr)
                `OFS_CTL0:     prdata <= {24'h000000, timer_control_zero_r};
                `OFS_CTL1:     prdata <= {24'h000000, timer_control_one_r};
                `OFS_OUT_CTL:  prdata <= {24'h000000, timer_output_control_r};
                `OFS_IN_EDGE:  prdata <= {24'h000000, input_edge_control_r};
                `OFS_CMP0:     prdata <= {16'h0000, cmp_r[0]};
                `OFS_CMP1:     prdata <= {16'h0000, cmp_r[1]};
                `OFS_CMP2:     prdata <= {16'h0000, cmp_r[2]};
                `OFS_CMP3:     prdata <= {16'h0000, cmp_r[3]};
                `OFS_COUNT:    prdata <= {16'h0000, count_r};
                `OFS_IRQ_STAT: prdata <= {28'h0000000, stat_r};
                `OFS_IRQ_MASK: prdata <= {28'h0000000, mask_r};
                default:       prdata <= 32'h00000000;
            endcase
        end
    end
endmodule // interval_timer

// ---- design/interval_timer_map.vh ----
// register offsets, field positions, reset values and timing counts of the interval timer
`ifndef INTERVAL_TIMER_MAP_VH
`define INTERVAL_TIMER_MAP_VH
// ==========================================
// register byte offsets
`define OFS_CTL0        12'h000
`define OFS_CTL1        12'h004
`define OFS_OUT_CTL     12'h008
`define OFS_IN_EDGE     12'h00C
`define OFS_CMP0        12'h010
`define OFS_CMP1        12'h014
`define OFS_CMP2        12'h018
`define OFS_CMP3        12'h01C
`define OFS_COUNT       12'h020
`define OFS_IRQ_STAT    12'h024
`define OFS_IRQ_MASK    12'h028
// ==========================================
// control zero fields
`define CTL0_RUN_BIT    7
// control one fields
`define CTL1_MODE_LSB   0
`define CTL1_MODE_MSB   2
`define CTL1_EXT_CLK    5
`define CTL1_SW_TRIG    6
// input edge control fields
`define EDGE_CAP_LSB    0
`define EDGE_CAP_MSB    1
// ==========================================
// operating modes
`define MODE_INTERVAL   3'h0
`define MODE_EVENT      3'h1
`define MODE_EXT_TRIG   3'h2
`define MODE_ONE_SHOT   3'h3
`define MODE_PWM        3'h4
`define MODE_FREE_RUN   3'h5
`define MODE_PULSE_W    3'h6
`define MODE_TRI_PWM    3'h7
// ==========================================
// reset values
`define RST_CTL0        8'h00
`define RST_CTL1        8'h00
`define RST_OUT_CTL     8'h00
`define RST_IN_EDGE     8'h00
`define RST_CMP         16'h0000
`define RST_MASK        4'h0
`define CNT_IDLE        16'hFFFF
`define CNT_ZERO        16'h0000
// count clock prescale, pclk cycles per count clock
`define PRESCALE_DEF    4
`endif

// ---- dv/interval_timer_monitor.sv ----
// port-level assertion checker for the interval timer
`timescale 1ns/1ps
// ====================
// checker
module interval_timer_monitor #(
    parameter PRESCALE = 4
) (
    // clock and reset
    input wire        pclk,
    input wire        presetn,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // interrupt and status
    input wire        irq,
    input wire        channel0_match_irq,
    input wire        capture_mode
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    // anything past the mask register or off a word boundary is unmapped
    wire bad = paddr > 12'h028 || paddr[1:0] != 2'h0;

    a_pready_high: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (acc && bad |-> pslverr) else $error("no error on unmapped access");
    a_ok_mapped: assert property (acc && !bad |-> !pslverr) else $error("error on mapped access");
    a_err_idle: assert property (!acc |-> !pslverr) else $error("error outside access phase");
    a_read_zero: assert property (acc && !pwrite && bad |-> prdata == 32'h00000000)
        else $error("unmapped read not zero");
    a_trig_reads0: assert property (acc && !pwrite && paddr == 12'h004 |-> !prdata[6])
        else $error("trigger strobe read back");
    a_pulse_gap: assert property (channel0_match_irq && PRESCALE >= 4 |=> !channel0_match_irq [*3])
        else $error("match pulses too close");
    a_capmode_cause: assert property ($changed(capture_mode) |-> $past(acc && pwrite && paddr == 12'h004))
        else $error("capture mode changed without write");
    a_irq_cause: assert property ($rose(irq) |-> $past(acc && pwrite && paddr == 12'h028) or ##[0:1] channel0_match_irq)
        else $error("irq rose without cause");

    c_match: cover property (channel0_match_irq);
    c_unmapped: cover property (acc && bad);
    c_irq: cover property ($rose(irq));
endmodule // interval_timer_monitor

bind interval_timer interval_timer_monitor #(.PRESCALE(PRESCALE)) interval_timer_monitor_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .channel0_match_irq(channel0_match_irq), .capture_mode(capture_mode));

// ---- dv/interval_timer_tb.sv ----
// self-checking testbench of the interval timer
`timescale 1ns/1ps
`include "interval_timer_map.vh"
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin err_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, a); end end
module interval_timer_tb;
    // short prescale keeps runs brief
    localparam PRE = 4;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        trig_pin = 1'b0;
    logic        event_pin = 1'b0;
    logic        clk_en_i = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] rd;
    logic        er;
    wire  [31:0] prdata;
    wire  [3:0]  timer_out;
    wire         pready, pslverr, irq, channel0_match_irq, capture_mode;
    integer      err_count = 0;
    integer      total_checks = 0;

    interval_timer #(.PRESCALE(PRE)) interval_timer_inst (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trig_pin(trig_pin), .event_pin(event_pin), .timer_out(timer_out),
        .irq(irq), .channel0_match_irq(channel0_match_irq), .capture_mode(capture_mode));

    always #5 pclk = ~pclk;
    // ====================
    // bus and helpers
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        integer n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) err_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_pulse(output integer t);
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (channel0_match_irq !== 1'b1 && t < 2000);
        if (t >= 2000) err_count++;
    endtask

    task automatic pulse_evt;
        event_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        event_pin <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    // ====================
    // scenarios
    task automatic t_pins;
        apb(1'b0, `OFS_OUT_CTL, 32'h0);
        `CHK("out_ctl reset", 8'h00, rd[7:0])
        for (int n = 0; n < 4; n++) begin
            apb(1'b1, `OFS_OUT_CTL, 32'h2 << (2 * n));
            `CHK("idle level", 4'h1 << n, timer_out)
        end
        apb(1'b1, `OFS_OUT_CTL, 32'hFF);
        `CHK("enabled pins", 4'h0, timer_out)
        apb(1'b0, `OFS_OUT_CTL, 32'h0);
        `CHK("out_ctl read", 8'hFF, rd[7:0])
        apb(1'b0, 12'h02C, 32'h0);
        `CHK("unmapped err", 1'b1, er)
        `CHK("unmapped data", 32'h0, rd)
    endtask

    task automatic t_modes;
        for (int m = 0; m < 16; m++) begin
            apb(1'b1, `OFS_CTL1, (m & 7) | ((m & 8) << 1));
            `CHK("capture mode", m[2:0] == 3'h6 || (m[2:0] == 3'h5 && m[3]), capture_mode)
        end
        apb(1'b1, `OFS_CTL1, 32'h0);
    endtask

    task automatic t_interval(input logic [15:0] d);
        integer t;
        apb(1'b1, `OFS_OUT_CTL, 32'h01);
        apb(1'b1, `OFS_IRQ_MASK, 32'h1);
        apb(1'b1, `OFS_CMP0, {16'h0, d});
        // trigger strobe and pin must not disturb interval mode
        apb(1'b1, `OFS_CTL1, 32'h40);
        apb(1'b0, `OFS_COUNT, 32'h0);
        `CHK("idle count", 16'hFFFF, rd[15:0])
        trig_pin <= 1'b1;
        apb(1'b1, `OFS_CTL0, 32'h80);
        wait_pulse(t);
        `CHK("pin0 first match", 1'b0, timer_out[0])
        `CHK("irq level", 1'b1, irq)
        wait_pulse(t);
        `CHK("period", (d + 1) * PRE, t)
        `CHK("pin0 toggle", 1'b1, timer_out[0])
        trig_pin <= 1'b0;
        apb(1'b1, `OFS_CTL0, 32'h0);
        apb(1'b0, `OFS_IRQ_STAT, 32'h0);
        `CHK("status", 1'b1, rd[0])
        `CHK("irq cleared", 1'b0, irq)
    endtask

    task automatic t_mask;
        integer t;
        apb(1'b1, `OFS_IRQ_MASK, 32'h0);
        apb(1'b1, `OFS_CMP0, 32'h1);
        apb(1'b1, `OFS_CTL0, 32'h80);
        wait_pulse(t);
        `CHK("masked irq", 1'b0, irq)
        apb(1'b1, `OFS_CTL0, 32'h0);
        apb(1'b1, `OFS_IRQ_MASK, 32'h1);
        `CHK("unmasked irq", 1'b1, irq)
        apb(1'b0, `OFS_IRQ_STAT, 32'h0);
        apb(1'b0, `OFS_IRQ_STAT, 32'h0);
        `CHK("status cleared", 32'h0, rd)
    endtask

    task automatic t_event;
        apb(1'b1, `OFS_IN_EDGE, 32'h0);
        apb(1'b1, `OFS_CMP0, 32'h1);
        apb(1'b1, `OFS_CTL1, 32'h1);
        apb(1'b1, `OFS_CTL0, 32'h80);
        pulse_evt;
        pulse_evt;
        apb(1'b0, `OFS_IRQ_STAT, 32'h0);
        `CHK("events short", 1'b0, rd[0])
        pulse_evt;
        apb(1'b0, `OFS_IRQ_STAT, 32'h0);
        `CHK("events match", 1'b1, rd[0])
        apb(1'b1, `OFS_CTL0, 32'h0);
        apb(1'b1, `OFS_CTL1, 32'h0);
    endtask

    task automatic t_freeze;
        logic p;
        apb(1'b1, `OFS_CMP0, 32'h0);
        apb(1'b1, `OFS_CTL0, 32'h80);
        repeat (10) @(posedge pclk);
        clk_en_i <= 1'b0;
        @(posedge pclk);
        p = timer_out[0];
        repeat (20) @(posedge pclk);
        `CHK("frozen pin", p, timer_out[0])
        clk_en_i <= 1'b1;
        @(posedge pclk);
        apb(1'b1, `OFS_CTL0, 32'h0);
    endtask

    task automatic print_verdict;
        if (err_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ====================
    // sequence and watchdog
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_pins;
        t_modes;
        t_interval(16'h0000);
        t_interval(16'h0003);
        t_mask;
        t_event;
        t_freeze;
        print_verdict;
    end

    initial begin
        #200000;
        err_count++;
        print_verdict;
    end
endmodule // interval_timer_tb
